// ==== verilog/pca_auth_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_auth_seq import pca_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Control
    input wire logic start,
    input wire logic renew,
    input wire logic other_derive,
    input wire logic visit_mode,
    input wire logic visit_load,
    input wire pca_pair_t visit_pair,
    // Session key derivation
    output logic skd_req,
    output logic [SEED_W-1:0] skd_seed,
    input wire logic skd_done,
    input wire logic [KEY_W-1:0] skd_key,
    // Response derivation
    output logic rd_req,
    output pca_rd_in_t rd_in,
    input wire logic rd_done,
    input wire pca_rd_out_t rd_out,
    // Air interface
    output logic req_valid,
    output pca_air_req_t req,
    input wire logic reply_valid,
    input wire pca_air_reply_t reply,
    // Result
    output logic busy,
    output logic auth_ok,
    output logic auth_fail,
    output logic dck_valid,
    output logic [DCK_W-1:0] derived_cipher_key
);

    // ==========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ==========================================================
    // State
    pca_state_t state_q;
    pca_state_t state_d;
    logic [HALF_W-1:0] fixed_seed_low;
    logic [HALF_W-1:0] fixed_seed_high;
    logic [CHAL_W/2-1:0] chal_lo;
    logic [CHAL_W/2-1:0] chal_hi;
    pca_pair_t pair_q;
    logic store_valid;
    logic store_pinned;
    logic store_load;
    logic store_pin;
    pca_pair_t store_pair;
    logic match;
    logic [RESP_W-1:0] presp_q;

    // ==========================================================
    // Fresh value sources
    // values never repeat
    pca_fresh_gen #(.W(SEED_W), .POLY(SEED_POLY), .INIT(SEED_INIT)) u_seed (
        .mclk(mclk),
        .rst_n(rst_n),
        .step(state_q == S_SEED),
        .lo_q(fixed_seed_low),
        .hi_q(fixed_seed_high)
    );

    pca_fresh_gen #(.W(CHAL_W), .POLY(CHAL_POLY), .INIT(CHAL_INIT)) u_chal (
        .mclk(mclk),
        .rst_n(rst_n),
        .step(state_q == S_CHAL),
        .lo_q(chal_lo),
        .hi_q(chal_hi)
    );

    // ==========================================================
    // Session key store
    always_comb begin
        store_load = 1'b0;
        store_pin = 1'b0;
        store_pair = '0;
        if (visit_load && state_q == S_IDLE) begin
            store_load = 1'b1;
            store_pin = visit_mode;
            store_pair = visit_pair;
        end else if (state_q == S_DWAIT && skd_done) begin
            store_load = 1'b1;
            store_pair.seed = skd_seed;
            store_pair.session_key = skd_key;
        end
    end

    pca_key_store u_store (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(store_load),
        .pin(store_pin),
        .load_pair(store_pair),
        .invalidate(renew || other_derive),
        .pair_q(pair_q),
        .valid_q(store_valid),
        .pinned_q(store_pinned)
    );

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (start && !visit_load) begin
                    if (store_valid && (store_pinned || !renew)) begin
                        state_d = S_CHAL;
                    end else begin
                        state_d = S_SEED;
                    end
                end
            end
            S_SEED: state_d = S_DRV;
            S_DRV: state_d = S_DWAIT;
            S_DWAIT: begin
                if (skd_done) begin
                    state_d = S_CHAL;
                end
            end
            S_CHAL: state_d = S_SEND;
            S_SEND: state_d = S_WAIT;
            S_WAIT: begin
                if (reply_valid) begin
                    state_d = S_RESP;
                end
            end
            S_RESP: state_d = S_RWAIT;
            S_RWAIT: begin
                if (rd_done) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            busy <= (state_d != S_IDLE);
        end
    end

    // ==========================================================
    // Session key derivation request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            skd_req <= 1'b0;
            skd_seed <= '0;
        end else begin
            skd_req <= (state_q == S_SEED);
            if (state_q == S_SEED) begin
                skd_seed <= {fixed_seed_high, fixed_seed_low};
            end
        end
    end

    // ==========================================================
    // Air request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_valid <= 1'b0;
            req <= '0;
        end else begin
            req_valid <= (state_q == S_CHAL);
            if (state_q == S_CHAL) begin
                req.fixed_challenge <= {chal_hi, chal_lo};
                req.combined_fixed_seed <= pair_q.seed;
            end
        end
    end

    // ==========================================================
    // Response derivation request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_req <= 1'b0;
            rd_in <= '0;
        end else begin
            rd_req <= (state_q == S_WAIT && reply_valid);
            if (state_q == S_WAIT && reply_valid) begin
                rd_in.session_key <= pair_q.session_key;
                rd_in.fixed_challenge <= req.fixed_challenge;
                rd_in.portable_challenge <= reply.portable_challenge;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presp_q <= '0;
        end else if (state_q == S_WAIT && reply_valid) begin
            presp_q <= reply.portable_response;
        end
    end

    // ==========================================================
    // Verdict and cipher key
    // exact match only
    assign match = (rd_out.expected_response == presp_q);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            auth_ok <= 1'b0;
            auth_fail <= 1'b0;
        end else begin
            auth_ok <= (state_q == S_RWAIT && rd_done && match);
            auth_fail <= (state_q == S_RWAIT && rd_done && !match);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dck_valid <= 1'b0;
            derived_cipher_key <= '0;
        end else if (state_q == S_RWAIT && rd_done && match) begin
            dck_valid <= 1'b1;
            derived_cipher_key <= rd_out.derived_cipher_key;
        end
    end

    // ==========================================================
    // Checks
    logic [SEED_W-1:0] last_skd_q;
    logic [CHAL_W-1:0] last_chal_q;
    logic seen_skd_q;
    logic seen_chal_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_skd_q <= '0;
            last_chal_q <= '0;
            seen_skd_q <= 1'b0;
            seen_chal_q <= 1'b0;
        end else begin
            if (skd_req) begin
                last_skd_q <= skd_seed;
                seen_skd_q <= 1'b1;
            end
            if (req_valid) begin
                last_chal_q <= req.fixed_challenge;
                seen_chal_q <= 1'b1;
            end
        end
    end

    seed_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        skd_req && seen_skd_q |-> skd_seed != last_skd_q)
        else $error("seed fed to derivation twice");
    chal_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req_valid && seen_chal_q |-> req.fixed_challenge != last_chal_q)
        else $error("fixed challenge repeated");
    seed_layout_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == S_SEED |=>
        skd_seed[SEED_W-1:HALF_W] == $past(fixed_seed_high) &&
        skd_seed[HALF_W-1:0] == $past(fixed_seed_low))
        else $error("seed halves misplaced");
    req_seed_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req_valid |-> req.combined_fixed_seed == pair_q.seed && !$past(req_valid))
        else $error("request seed differs from stored seed");
    derive_fresh_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == S_IDLE && start && !visit_load && !store_valid
        |=> state_q == S_SEED ##1 skd_req)
        else $error("no fresh derivation started");
    visit_seed_a: assert property (@(posedge mclk) disable iff (!rst_n)
        req_valid && store_pinned |-> req.combined_fixed_seed == pair_q.seed
        && state_q == S_SEND)
        else $error("visited seed not sent");
    ok_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == S_RWAIT && rd_done && match |=>
        auth_ok && dck_valid &&
        derived_cipher_key == $past(rd_out.derived_cipher_key))
        else $error("cipher key not taken on success");
    fail_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == S_RWAIT && rd_done && !match |=>
        auth_fail && !auth_ok && $stable(derived_cipher_key))
        else $error("failure changed key or not flagged");
    store_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        state_q == S_DWAIT && skd_done && !visit_load |=>
        pair_q.seed == $past(skd_seed) && pair_q.session_key == $past(skd_key))
        else $error("derived pair not kept");

endmodule
`default_nettype wire

// ==== inc/pca_pkg.sv ====
package pca_pkg;

    // ==========================================================
    // Widths
    localparam int HALF_W = 64;
    localparam int SEED_W = 128;
    localparam int KEY_W = 128;
    localparam int CHAL_W = 64;
    localparam int RESP_W = 32;
    localparam int DCK_W = 128;

    // ==========================================================
    // Generator feedback polynomials and start values
    localparam logic [HALF_W-1:0] SEED_POLY = 64'hd800_0000_0000_0000;
    localparam logic [CHAL_W/2-1:0] CHAL_POLY = 32'h8020_0003;
    localparam logic [HALF_W-1:0] SEED_INIT = 64'h0000_0000_0000_0001;
    localparam logic [CHAL_W/2-1:0] CHAL_INIT = 32'h0000_0001;

    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_SEED = 9'h002,
        S_DRV = 9'h004,
        S_DWAIT = 9'h008,
        S_CHAL = 9'h010,
        S_SEND = 9'h020,
        S_WAIT = 9'h040,
        S_RESP = 9'h080,
        S_RWAIT = 9'h100
    } pca_state_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [SEED_W-1:0] seed;
        logic [KEY_W-1:0] session_key;
    } pca_pair_t;

    typedef struct packed {
        logic [CHAL_W-1:0] fixed_challenge;
        logic [SEED_W-1:0] combined_fixed_seed;
    } pca_air_req_t;

    typedef struct packed {
        logic [RESP_W-1:0] portable_response;
        logic [CHAL_W-1:0] portable_challenge;
    } pca_air_reply_t;

    typedef struct packed {
        logic [KEY_W-1:0] session_key;
        logic [CHAL_W-1:0] fixed_challenge;
        logic [CHAL_W-1:0] portable_challenge;
    } pca_rd_in_t;

    typedef struct packed {
        logic [RESP_W-1:0] expected_response;
        logic [DCK_W-1:0] derived_cipher_key;
    } pca_rd_out_t;

endpackage

// ==== verilog/pca_fresh_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_fresh_gen import pca_pkg::*; #(
    parameter int W = 128,
    parameter logic [W/2-1:0] POLY = '1,
    parameter logic [W/2-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Step and value
    input wire logic step,
    output logic [W/2-1:0] lo_q,
    output logic [W/2-1:0] hi_q
);

    // ==========================================================
    // Counter half never repeats, scrambler half adds spread
    logic [W/2-1:0] lfsr_q;
    logic [W/2-1:0] lfsr_d;

    always_comb begin
        lfsr_d = {lfsr_q[W/2-2:0], 1'b0} ^ (lfsr_q[W/2-1] ? POLY : '0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_q <= INIT;
            lo_q <= '0;
            hi_q <= '0;
        end else if (step) begin
            lfsr_q <= lfsr_d;
            lo_q <= lo_q + (W/2)'(1);
            hi_q <= lfsr_d;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/pca_key_store.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_key_store import pca_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Loading
    input wire logic load,
    input wire logic pin,
    input wire pca_pair_t load_pair,
    input wire logic invalidate,
    // Stored pair
    output pca_pair_t pair_q,
    output logic valid_q,
    output logic pinned_q
);

    // ==========================================================
    // Last derived or provided pair, load wins over invalidate
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pair_q <= '0;
            valid_q <= 1'b0;
            pinned_q <= 1'b0;
        end else if (load) begin
            pair_q <= load_pair;
            valid_q <= 1'b1;
            pinned_q <= pin;
        end else if (invalidate && !pinned_q) begin
            valid_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== test/pca_tb_pkg.sv ====
`default_nettype none
package pca_tb_pkg;
    import pca_pkg::*;

    // Terminal authentication key, arbitrary
    localparam logic [KEY_W-1:0] AUTH_K =
        128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;

    function automatic logic [KEY_W-1:0] skd_f(input logic [SEED_W-1:0] s);
        return {s[63:0], s[127:64]} ^ AUTH_K;
    endfunction

    function automatic pca_rd_out_t rd_f(input pca_rd_in_t i);
        pca_rd_out_t o;
        o.expected_response = i.session_key[31:0] ^
            i.fixed_challenge[63:32] ^ i.portable_challenge[31:0];
        o.derived_cipher_key = i.session_key ^
            {i.fixed_challenge, i.portable_challenge};
        return o;
    endfunction
endpackage
`default_nettype wire

// ==== test/pca_portable_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pca_portable_model import pca_pkg::*, pca_tb_pkg::*; (
    // Clock
    input wire logic mclk,
    // Air request
    input wire logic req_valid,
    input wire pca_air_req_t req,
    // Air reply
    output logic reply_valid,
    output pca_air_reply_t reply,
    // Test control
    input wire logic corrupt,
    input wire logic [3:0] max_delay
);
    logic [SEED_W-1:0] st_seed;
    logic [KEY_W-1:0] st_key;
    logic st_valid;
    pca_rd_in_t rin;
    pca_rd_out_t rout;

    // ==========================================================
    // Answering process
    initial begin
        reply_valid = 1'b0;
        reply = '0;
        st_valid = 1'b0;
        forever begin
            @(negedge mclk);
            if (req_valid) begin
                rin.fixed_challenge = req.fixed_challenge;
                rin.portable_challenge = {$urandom, $urandom};
                if (!st_valid || st_seed !== req.combined_fixed_seed) begin
                    st_seed = req.combined_fixed_seed;
                    st_key = skd_f(st_seed);
                    st_valid = 1'b1;
                end
                rin.session_key = st_key;
                rout = rd_f(rin);
                repeat ($urandom_range(max_delay, 1)) @(posedge mclk);
                #1;
                // reply with response and own challenge
                reply_valid = 1'b1;
                reply.portable_response =
                    rout.expected_response ^ {31'h0, corrupt};
                reply.portable_challenge = rin.portable_challenge;
                @(posedge mclk);
                #1;
                reply_valid = 1'b0;
                reply = ~reply;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/test_portable_challenge_auth.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_portable_challenge_auth import pca_pkg::*, pca_tb_pkg::*;;
    logic mclk, resetn, start, renew, other_derive, visit_mode, visit_load;
    logic skd_req, skd_done, rd_req, rd_done, req_valid, reply_valid;
    logic busy, auth_ok, auth_fail, dck_valid, corrupt;
    pca_pair_t visit_pair;
    logic [SEED_W-1:0] skd_seed, cur_seed;
    logic [KEY_W-1:0] skd_key, cur_key;
    pca_rd_in_t rd_in;
    pca_rd_out_t rd_out, rout;
    pca_air_req_t req;
    pca_air_reply_t reply;
    logic [DCK_W-1:0] derived_cipher_key, good_dck;
    logic [CHAL_W-1:0] sent_fc, got_pc;
    logic [3:0] max_delay;
    logic [DCK_W:0] notes[$];
    bit seen_seed[logic [SEED_W-1:0]];
    bit seen_chal[logic [CHAL_W-1:0]];
    int n_errors = 0;
    int comparisons = 0;
    int skd_cnt = 0;
    int r;

    pca_auth_seq uut (.mclk(mclk), .resetn(resetn), .start(start),
        .renew(renew), .other_derive(other_derive), .visit_mode(visit_mode),
        .visit_load(visit_load), .visit_pair(visit_pair),
        .skd_req(skd_req), .skd_seed(skd_seed), .skd_done(skd_done),
        .skd_key(skd_key), .rd_req(rd_req), .rd_in(rd_in),
        .rd_done(rd_done), .rd_out(rd_out), .req_valid(req_valid),
        .req(req), .reply_valid(reply_valid), .reply(reply), .busy(busy),
        .auth_ok(auth_ok), .auth_fail(auth_fail), .dck_valid(dck_valid),
        .derived_cipher_key(derived_cipher_key));

    pca_portable_model u_pt (.mclk(mclk), .req_valid(req_valid),
        .req(req), .reply_valid(reply_valid), .reply(reply),
        .corrupt(corrupt), .max_delay(max_delay));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Compare and close
    task automatic check(input logic [DCK_W:0] seen, input logic [DCK_W:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Derivation engines
    initial begin
        forever begin
            @(negedge mclk);
            if (skd_req) begin
                check(seen_seed.exists(skd_seed), 0);
                seen_seed[skd_seed] = 1'b1;
                skd_cnt++;
                repeat ($urandom_range(4, 1)) @(posedge mclk);
                #1;
                skd_done = 1'b1;
                skd_key = skd_f(skd_seed);
                cur_seed = skd_seed;
                cur_key = skd_key;
                @(posedge mclk);
                #1;
                skd_done = 1'b0;
                skd_key = ~skd_key;
            end
        end
    end

    initial begin
        forever begin
            @(negedge mclk);
            if (rd_req) begin
                check(rd_in.session_key, cur_key);
                check(rd_in.fixed_challenge, sent_fc);
                check(rd_in.portable_challenge, got_pc);
                rout = rd_f(pca_rd_in_t'({cur_key, sent_fc, got_pc}));
                if (!corrupt)
                    good_dck = rout.derived_cipher_key;
                notes.push_back({corrupt, good_dck});
                repeat ($urandom_range(3, 1)) @(posedge mclk);
                #1;
                rd_done = 1'b1;
                rd_out = rout;
                @(posedge mclk);
                #1;
                rd_done = 1'b0;
                rd_out = ~rout;
            end
        end
    end

    // ==========================================================
    // Output monitor
    always @(negedge mclk) begin
        if (reply_valid)
            got_pc = reply.portable_challenge;
        if (req_valid) begin
            check(req.combined_fixed_seed, cur_seed);
            check(seen_chal.exists(req.fixed_challenge), 0);
            seen_chal[req.fixed_challenge] = 1'b1;
            sent_fc = req.fixed_challenge;
        end
        if (auth_ok || auth_fail) begin
            check(notes.size() > 0, 1);
            if (notes.size() > 0)
                check({auth_fail, derived_cipher_key}, notes.pop_front());
            check(dck_valid, 1);
        end
    end

    // ==========================================================
    // Stimulus
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(posedge mclk);
        #1;
        s = 1'b0;
    endtask

    task automatic auth(input bit exp_derive, input bit bad);
        int n0;
        int t;
        n0 = skd_cnt;
        t = 0;
        corrupt = bad;
        max_delay = 4'($urandom_range(6, 1));
        pulse(start);
        check(busy, 1);
        while (busy !== 1'b0 && t < 1000) begin
            @(posedge mclk);
            #1;
            t++;
        end
        check(t < 1000, 1);
        check(skd_cnt - n0, exp_derive);
    endtask

    initial begin
        void'($urandom(32'h35c20a52));
        {start, renew, other_derive, visit_mode, visit_load} = '0;
        {skd_done, rd_done, corrupt} = '0;
        visit_pair = '0;
        skd_key = '0;
        rd_out = '0;
        max_delay = 4'h1;
        resetn = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        check({busy, auth_ok, auth_fail, dck_valid}, 0);
        check({skd_req, req_valid, rd_req}, 0);
        resetn = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        auth(1, 0);
        auth(0, 0);
        auth(0, 1);
        pulse(renew);
        auth(1, 0);
        pulse(other_derive);
        auth(1, 0);
        for (int i = 0; i < 6; i++) begin
            r = $urandom_range(1, 0);
            if (r == 1)
                pulse(renew);
            auth(r[0], 1'($urandom_range(1, 0)));
        end
        visit_mode = 1'b1;
        visit_pair.seed = {$urandom, $urandom, $urandom, $urandom};
        visit_pair.session_key = skd_f(visit_pair.seed);
        pulse(visit_load);
        cur_seed = visit_pair.seed;
        cur_key = visit_pair.session_key;
        auth(0, 0);
        pulse(renew);
        auth(0, 0);
        repeat (4) @(posedge mclk);
        conclude();
    end

    initial begin
        #500000;
        n_errors++;
        conclude();
    end
endmodule
`default_nettype wire
